// [rtl/ccrr_pkg.sv]
package ccrr_pkg;

  // card-specific data, layout version 2.0, msb first
  typedef struct packed {
    logic [1:0]  layout_version_field;
    logic [5:0]  rsv_125;
    logic [7:0]  read_latency_code;
    logic [7:0]  read_latency_cycle_count;
    logic [7:0]  max_transfer_rate;
    logic [11:0] command_class_mask;
    logic [3:0]  max_read_block_length;
    logic        partial_read_permit;
    logic        write_crossing_permit;
    logic        read_crossing_permit;
    logic        driver_stage_reg_present;
    logic [5:0]  rsv_75;
    logic [21:0] device_size;
    logic        rsv_47;
    logic        single_block_erase_enable;
    logic [6:0]  erase_sector_size;
    logic [6:0]  protect_group_span;
    logic        protect_group_enable;
    logic [1:0]  rsv_30;
    logic [2:0]  write_speed_factor;
    logic [3:0]  max_write_block_length;
    logic        partial_write_permit;
    logic [4:0]  rsv_20;
    logic        format_group_flag;
    logic        copy_flag;
    logic        permanent_lock;
    logic        temporary_lock;
    logic [1:0]  file_format;
    logic [1:0]  rsv_9;
    logic [6:0]  crc7;
    logic        end_one;
  } ccrr_csd_type;

  // feature configuration, 64 bits, msb first
  typedef struct packed {
    logic [3:0]  config_layout_version;
    logic [3:0]  spec_version_code;
    logic        erase_data_state;
    logic [2:0]  security_support_code;
    logic [3:0]  supported_width_mask;
    logic        spec3_or_later;
    logic [3:0]  extended_security_code;
    logic        spec4_or_later;
    logic [3:0]  spec5_plus_code;
    logic [1:0]  rsv_37;
    logic [3:0]  command_support;
    logic [31:0] maker_use;
  } ccrr_scr_type;

  typedef enum logic [1:0] {
    CCRR_ACC_READ       = 2'b00,
    CCRR_ACC_WRITE_ONCE = 2'b01,
    CCRR_ACC_WRITE_MANY = 2'b10
  } ccrr_access_type;

  localparam int          CSD_WIDTH        = 128;
  localparam int          SCR_WIDTH        = 64;
  localparam int          STAT_WIDTH       = 512;
  localparam int          CRC16_WIDTH      = 16;

  localparam logic [1:0]  CSD_LAYOUT_V2    = 2'h1;
  localparam logic [7:0]  CSD_LATENCY_CODE = 8'h0E;
  localparam logic [7:0]  CSD_LATENCY_CYC  = 8'h00;
  localparam logic [11:0] CSD_CLASS_MASK   = 12'h5B5;
  localparam logic [3:0]  CSD_BLOCK_LEN    = 4'h9;
  localparam logic [6:0]  CSD_SECTOR_SIZE  = 7'h7F;
  localparam logic [2:0]  CSD_SPEED_FACTOR = 3'h2;
  localparam logic [6:0]  CSD_CRC7_POLY    = 7'h09;
  localparam int          CSD_COPY_BIT     = 14;
  localparam int          CSD_PERM_BIT     = 13;
  localparam int          CSD_TEMP_BIT     = 12;
  localparam int          CSD_CRC_LSB      = 8;

  localparam logic [3:0]  SCR_LAYOUT       = 4'h0;
  localparam logic [3:0]  SCR_SPEC_VERSION = 4'h2;
  localparam logic [2:0]  SCR_SECURITY     = 3'h3;
  localparam logic [3:0]  SCR_WIDTHS       = 4'h5;

  localparam int          STAT_WIDTH_MSB   = 511;
  localparam int          STAT_SECURED_BIT = 509;
  localparam int          STAT_TYPE_LSB    = 480;
  localparam int          STAT_SPEED_LSB   = 440;
  localparam int          STAT_AU_LSB      = 428;
  localparam int          STAT_ERASE_LSB   = 408;
  localparam logic [1:0]  STAT_BUS_1BIT    = 2'h0;
  localparam logic [1:0]  STAT_BUS_4BIT    = 2'h2;
  localparam logic [15:0] STAT_CARD_TYPE   = 16'h0000;
  localparam logic [15:0] CRC16_POLY       = 16'h1021;
  localparam logic [3:0]  LANES_WIDE       = 4'hF;
  localparam logic [3:0]  LANES_NARROW     = 4'h1;

endpackage

// [rtl/ccrr_dat_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// runs entirely on the host-driven card clock; blk and wide stay stable
// in the core domain from the request toggle until the done toggle returns
module ccrr_dat_tx
  import ccrr_pkg::*;
(
  input  wire logic                  sd_clk,
  input  wire logic                  resetn,
  input  wire logic                  req_tgl,
  input  wire logic [STAT_WIDTH-1:0] blk,
  input  wire logic                  wide,
  output logic      [3:0]            dat_out,
  output logic      [3:0]            dat_oe,
  output logic                       done_tgl
);

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_CRC   = 3'b011,
    TX_STOP  = 3'b100
  } ccrr_tx_state_type;

  ccrr_tx_state_type      state_r;
  logic [1:0]             rst_sync_r;
  logic [2:0]             req_sync_r;
  logic [STAT_WIDTH-1:0]  sh_r;
  logic                   wide_r;
  logic [8:0]             cnt_r;
  logic [CRC16_WIDTH-1:0] crc_r   [4];
  logic [CRC16_WIDTH-1:0] crc_nxt [4];
  logic [3:0]             cur_bits;
  logic [3:0]             lanes;
  logic [8:0]             last_cnt;
  logic                   link_rst_n;

  assign link_rst_n = rst_sync_r[1];
  assign lanes      = wide_r ? LANES_WIDE : LANES_NARROW;
  assign last_cnt   = wide_r ? 9'h07F : 9'h1FF;
  // wide bus: msb nibble first, dat3 carries the highest bit
  assign cur_bits   = wide_r ? sh_r[STAT_WIDTH-1 -: 4] : {3'h0, sh_r[STAT_WIDTH-1]};

  always_ff @(posedge sd_clk) begin
    rst_sync_r <= {rst_sync_r[0], resetn};
  end

  always_ff @(posedge sd_clk) begin
    if (!link_rst_n) begin
      req_sync_r <= 3'h0;
    end else begin
      req_sync_r <= {req_sync_r[1:0], req_tgl};
    end
  end

  // one crc16 for each of the four lanes, active or not, fed with the bit leaving that lane
  for (genvar g = 0; g < 4; g++) begin : g_crc
    always_comb begin
      crc_nxt[g] = {crc_r[g][CRC16_WIDTH-2:0], 1'b0};
      if (cur_bits[g] ^ crc_r[g][CRC16_WIDTH-1]) begin
        crc_nxt[g] = crc_nxt[g] ^ CRC16_POLY;
      end
    end
  end

  always_ff @(posedge sd_clk) begin
    if (!link_rst_n) begin
      state_r  <= TX_IDLE;
      sh_r     <= '0;
      wide_r   <= 1'b0;
      cnt_r    <= 9'h000;
      dat_out  <= 4'hF;
      dat_oe   <= 4'h0;
      done_tgl <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        crc_r[i] <= '0;
      end
    end else begin
      unique case (state_r)
        TX_IDLE: begin
          dat_oe  <= 4'h0;
          dat_out <= 4'hF;
          if (req_sync_r[2] != req_sync_r[1]) begin
            sh_r    <= blk;
            wide_r  <= wide;
            state_r <= TX_START;
          end
        end
        TX_START: begin
          dat_oe  <= lanes;
          dat_out <= ~lanes;
          cnt_r   <= 9'h000;
          for (int i = 0; i < 4; i++) begin
            crc_r[i] <= '0;
          end
          state_r <= TX_DATA;
        end
        TX_DATA: begin
          dat_out <= cur_bits | ~lanes;
          sh_r    <= wide_r ? {sh_r[STAT_WIDTH-5:0], 4'h0} : {sh_r[STAT_WIDTH-2:0], 1'b0};
          for (int i = 0; i < 4; i++) begin
            crc_r[i] <= crc_nxt[i];
          end
          if (cnt_r == last_cnt) begin
            cnt_r   <= 9'h000;
            state_r <= TX_CRC;
          end else begin
            cnt_r <= cnt_r + 9'h001;
          end
        end
        TX_CRC: begin
          for (int i = 0; i < 4; i++) begin
            dat_out[i] <= crc_r[i][CRC16_WIDTH-1] | ~lanes[i];
            crc_r[i]   <= {crc_r[i][CRC16_WIDTH-2:0], 1'b0};
          end
          if (cnt_r == 9'(CRC16_WIDTH - 1)) begin
            state_r <= TX_STOP;
          end else begin
            cnt_r <= cnt_r + 9'h001;
          end
        end
        TX_STOP: begin
          dat_out  <= 4'hF;
          done_tgl <= ~done_tgl;
          state_r  <= TX_IDLE;
        end
        default: begin
          state_r <= TX_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [rtl/ccrr_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - data layout version bits read 01b
// - compatibility fields hold constant values
// - read latency code is 0E hex
// - latency clock-cycle count is 00 hex
// - max read block length is 9 hex
// - partial block reads not permitted
// - single block erase enabled
// - protect group enable reads zero
// - partial block writes not permitted
// - each field has read, once or many access
// - feature configuration is exactly 64 bits
// - feature configuration fixed, host cannot change
// - spec 2, security 011b, widths 5 hex
// - status block is one 512-bit block
// - status sent on data lines plus crc16
// - status answered only in selected transfer state
// - unused reserved status bits are zero
// - top status bits give current bus width
module ccrr_top
  import ccrr_pkg::*;
#(
  parameter logic [21:0] DEVICE_SIZE    = 22'h007FFF,
  parameter logic [7:0]  TRANSFER_RATE  = 8'h32,
  parameter logic [7:0]  SPEED_CLASS    = 8'h00,
  parameter logic [3:0]  AU_SIZE        = 4'h0,
  parameter logic [15:0] ERASE_SIZE     = 16'h0000,
  parameter logic [3:0]  EXT_SECURITY   = 4'h0,
  parameter logic [31:0] MAKER_USE      = 32'h00000000
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  sd_clk,
  input  wire logic                  transfer_state,
  input  wire logic                  status_req,
  input  wire logic                  bus_wide,
  input  wire logic                  secured_mode,
  input  wire logic                  csd_prog_req,
  input  wire logic [CSD_WIDTH-1:0]  csd_prog_data,
  output logic      [CSD_WIDTH-1:0]  csd_value,
  output logic      [SCR_WIDTH-1:0]  scr_value,
  output logic                       status_busy,
  output logic                       status_done,
  output logic                       status_refused,
  output logic                       csd_prog_done,
  output logic                       csd_prog_refused,
  output logic      [3:0]            dat_out,
  output logic      [3:0]            dat_oe
);

  if (DEVICE_SIZE == 22'h000000) begin : g_chk_size
    $error("ccrr_top: DEVICE_SIZE must be non-zero");
  end
  if (AU_SIZE > 4'hF) begin : g_chk_au
    $error("ccrr_top: AU_SIZE out of range");
  end
  // field layouts must fill each register exactly
  if ($bits(ccrr_csd_type) != CSD_WIDTH) begin : g_chk_csd
    $error("ccrr_top: card data layout width wrong");
  end
  if ($bits(ccrr_scr_type) != SCR_WIDTH) begin : g_chk_scr
    $error("ccrr_top: feature layout width wrong");
  end
  // the program check and crc7 only cover bits above the checksum
  if (CSD_WIDTH - CSD_CRC_LSB != 120) begin : g_chk_crc
    $error("ccrr_top: checksum span wrong");
  end
  if (CSD_TEMP_BIT < CSD_CRC_LSB || CSD_COPY_BIT == CSD_PERM_BIT) begin : g_chk_lock
    $error("ccrr_top: lock bit positions wrong");
  end
  if (STAT_WIDTH_MSB != STAT_WIDTH - 1) begin : g_chk_stat
    $error("ccrr_top: bus width field misplaced");
  end
  if (STAT_ERASE_LSB + 16 > STAT_AU_LSB) begin : g_chk_fields
    $error("ccrr_top: status fields overlap");
  end

  // crc7 over the 120 bits above the checksum, msb first
  function automatic logic [6:0] crc7_of(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CSD_CRC7_POLY;
      end
    end
    return c;
  endfunction

  // only copy, permanent and temporary lock may be programmed
  function automatic ccrr_access_type csd_access(input int idx);
    if (idx == CSD_COPY_BIT || idx == CSD_PERM_BIT) begin
      return CCRR_ACC_WRITE_ONCE;
    end else if (idx == CSD_TEMP_BIT) begin
      return CCRR_ACC_WRITE_MANY;
    end
    return CCRR_ACC_READ;
  endfunction

  function automatic logic [CSD_WIDTH-1:0] csd_build(input logic copy_b, input logic perm_b,
                                                     input logic temp_b);
    ccrr_csd_type c;
    c                           = '0;
    c.layout_version_field      = CSD_LAYOUT_V2;
    c.read_latency_code         = CSD_LATENCY_CODE;
    c.read_latency_cycle_count  = CSD_LATENCY_CYC;
    c.max_transfer_rate         = TRANSFER_RATE;
    c.command_class_mask        = CSD_CLASS_MASK;
    c.max_read_block_length     = CSD_BLOCK_LEN;
    c.partial_read_permit       = 1'b0;
    c.write_crossing_permit     = 1'b0;
    c.read_crossing_permit      = 1'b0;
    c.driver_stage_reg_present  = 1'b0;
    c.device_size               = DEVICE_SIZE;
    c.single_block_erase_enable = 1'b1;
    c.erase_sector_size         = CSD_SECTOR_SIZE;
    c.protect_group_span        = 7'h00;
    c.protect_group_enable      = 1'b0;
    c.write_speed_factor        = CSD_SPEED_FACTOR;
    c.max_write_block_length    = CSD_BLOCK_LEN;
    c.partial_write_permit      = 1'b0;
    c.format_group_flag         = 1'b0;
    c.copy_flag                 = copy_b;
    c.permanent_lock            = perm_b;
    c.temporary_lock            = temp_b;
    c.file_format               = 2'h0;
    c.crc7                      = crc7_of(c[CSD_WIDTH-1:CSD_CRC_LSB]);
    c.end_one                   = 1'b1;
    return c;
  endfunction

  localparam logic [CSD_WIDTH-1:0] CSD_INIT = csd_build(1'b0, 1'b0, 1'b0);

  function automatic logic [SCR_WIDTH-1:0] scr_build();
    ccrr_scr_type s;
    s                        = '0;
    s.config_layout_version  = SCR_LAYOUT;
    s.spec_version_code      = SCR_SPEC_VERSION;
    s.security_support_code  = SCR_SECURITY;
    s.supported_width_mask   = SCR_WIDTHS;
    s.extended_security_code = EXT_SECURITY;
    s.maker_use              = MAKER_USE;
    return s;
  endfunction

  // the struct is 64 bits by construction; no write path reaches it
  localparam logic [SCR_WIDTH-1:0] SCR_INIT = scr_build();

  logic                  copy_r;
  logic                  perm_r;
  logic                  temp_r;
  logic                  prog_bad;
  logic [CSD_WIDTH-1:0]  cur_csd;
  logic [STAT_WIDTH-1:0] stat_nxt;
  logic [STAT_WIDTH-1:0] stat_blk_r;
  logic                  wide_r;
  logic                  req_tgl_r;
  logic                  tx_done_tgl;
  logic [2:0]            done_sync_r;
  logic                  done_seen;
  logic                  status_take;
  logic                  status_deny;
  logic                  prog_ok;

  assign cur_csd = csd_build(copy_r, perm_r, temp_r);
  assign prog_ok     = csd_prog_req && !prog_bad;
  // a request is served only while selected, in transfer state and idle
  assign status_take = status_req && transfer_state && !status_busy;
  assign status_deny = status_req && !status_take;

  // the field access class decides what a program request may touch
  always_comb begin
    prog_bad = 1'b0;
    for (int i = CSD_CRC_LSB; i < CSD_WIDTH; i++) begin
      unique case (csd_access(i))
        CCRR_ACC_READ: begin
          if (csd_prog_data[i] != cur_csd[i]) begin
            prog_bad = 1'b1;
          end
        end
        CCRR_ACC_WRITE_ONCE: begin
          if (cur_csd[i] && !csd_prog_data[i]) begin
            prog_bad = 1'b1;
          end
        end
        CCRR_ACC_WRITE_MANY: begin
          prog_bad = prog_bad;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      csd_prog_done    <= 1'b0;
      csd_prog_refused <= 1'b0;
    end else begin
      csd_prog_done    <= prog_ok;
      csd_prog_refused <= csd_prog_req && prog_bad;
    end
  end

  // copy and permanent lock only ever set; temporary lock follows the image
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      copy_r <= 1'b0;
      perm_r <= 1'b0;
      temp_r <= 1'b0;
    end else if (prog_ok) begin
      copy_r <= csd_prog_data[CSD_COPY_BIT] | copy_r;
      perm_r <= csd_prog_data[CSD_PERM_BIT] | perm_r;
      temp_r <= csd_prog_data[CSD_TEMP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      csd_value <= CSD_INIT;
      scr_value <= SCR_INIT;
    end else begin
      csd_value <= cur_csd;
      scr_value <= SCR_INIT;
    end
  end

  // everything not named here stays zero, reserved areas included
  always_comb begin
    stat_nxt = '0;
    stat_nxt[STAT_WIDTH_MSB -: 2]  = bus_wide ? STAT_BUS_4BIT : STAT_BUS_1BIT;
    stat_nxt[STAT_SECURED_BIT]     = secured_mode;
    stat_nxt[STAT_TYPE_LSB +: 16]  = STAT_CARD_TYPE;
    stat_nxt[STAT_SPEED_LSB +: 8]  = SPEED_CLASS;
    stat_nxt[STAT_AU_LSB +: 4]     = AU_SIZE;
    stat_nxt[STAT_ERASE_LSB +: 16] = ERASE_SIZE;
  end

  assign done_seen = done_sync_r[2] != done_sync_r[1];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      done_sync_r <= 3'h0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], tx_done_tgl};
    end
  end

  // one-cycle answers; a request while busy is refused, never queued
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_done    <= 1'b0;
      status_refused <= 1'b0;
    end else begin
      status_done    <= done_seen;
      status_refused <= status_deny;
    end
  end

  // busy spans from the accepted request to the returned done toggle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_busy <= 1'b0;
    end else if (status_take) begin
      status_busy <= 1'b1;
    end else if (done_seen) begin
      status_busy <= 1'b0;
    end
  end

  // snapshot stays frozen while busy so the link side reads it without a race
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stat_blk_r <= '0;
      wide_r     <= 1'b0;
      req_tgl_r  <= 1'b0;
    end else if (status_take) begin
      stat_blk_r <= stat_nxt;
      wide_r     <= bus_wide;
      req_tgl_r  <= ~req_tgl_r;
    end
  end

  ccrr_dat_tx u_dat_tx (
    .sd_clk   (sd_clk),
    .resetn   (resetn),
    .req_tgl  (req_tgl_r),
    .blk      (stat_blk_r),
    .wide     (wide_r),
    .dat_out  (dat_out),
    .dat_oe   (dat_oe),
    .done_tgl (tx_done_tgl)
  );

endmodule
`default_nettype wire

// [bench/ccrr_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ccrr_top_checker
  import ccrr_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 sd_clk,
  input wire logic                 transfer_state,
  input wire logic                 status_req,
  input wire logic                 bus_wide,
  input wire logic                 secured_mode,
  input wire logic                 csd_prog_req,
  input wire logic [CSD_WIDTH-1:0] csd_prog_data,
  input wire logic [CSD_WIDTH-1:0] csd_value,
  input wire logic [SCR_WIDTH-1:0] scr_value,
  input wire logic                 status_busy,
  input wire logic                 status_done,
  input wire logic                 status_refused,
  input wire logic                 csd_prog_done,
  input wire logic                 csd_prog_refused,
  input wire logic [3:0]           dat_out,
  input wire logic [3:0]           dat_oe
);
  // start, data, crc and end bit, all with the lane enabled
  localparam int FRAME_WIDE   = 146;
  localparam int FRAME_NARROW = 530;
  logic [9:0] frame_cnt_r;

  always_ff @(posedge sd_clk) begin
    if (!resetn || !dat_oe[0])
      frame_cnt_r <= 10'h000;
    else
      frame_cnt_r <= frame_cnt_r + 10'h001;
  end

  AST_CSD_LAYOUT: assert property (@(posedge ref_clk) disable iff (!resetn)
    csd_value[127:126] == 2'h1) else $error("layout version wrong");
  AST_CSD_LATENCY: assert property (@(posedge ref_clk) disable iff (!resetn)
    csd_value[119:104] == 16'h0E00) else $error("read latency fields wrong");
  AST_CSD_FLAGS: assert property (@(posedge ref_clk) disable iff (!resetn)
    {csd_value[83:79], csd_value[46], csd_value[31], csd_value[21], csd_value[0]} == 9'h129)
    else $error("fixed csd flags wrong");
  AST_SCR_FIXED: assert property (@(posedge ref_clk) disable iff (!resetn)
    $stable(scr_value) && scr_value[59:48] == 12'h235) else $error("feature config wrong");
  AST_ACCEPT: assert property (@(posedge ref_clk) disable iff (!resetn)
    status_req && transfer_state && !status_busy |=> status_busy && !status_refused)
    else $error("status request not taken");
  AST_REFUSE: assert property (@(posedge ref_clk) disable iff (!resetn)
    status_req && (!transfer_state || status_busy) |=> status_refused) else $error("no refusal");
  AST_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    status_done |-> $past(status_busy) ##1 !status_done) else $error("done without busy");
  AST_PROG_ANSWER: assert property (@(posedge ref_clk) disable iff (!resetn)
    csd_prog_req |=> csd_prog_done != csd_prog_refused) else $error("program not answered");
  AST_PROG_KEEP: assert property (@(posedge ref_clk) disable iff (!resetn)
    csd_prog_refused |=> $stable(csd_value)) else $error("refused program changed csd");
  AST_IDLE_LINES: assert property (@(posedge sd_clk) disable iff (!resetn)
    !status_busy |-> dat_oe == 4'h0) else $error("lines driven while idle");
  AST_START_BIT: assert property (@(posedge sd_clk) disable iff (!resetn)
    $rose(dat_oe[0]) |-> !dat_out[0] && (dat_oe == 4'h1 || dat_oe == 4'hF)) else $error("bad start");
  AST_FRAME_LEN: assert property (@(posedge sd_clk) disable iff (!resetn)
    $fell(dat_oe[0]) |-> frame_cnt_r == FRAME_WIDE || frame_cnt_r == FRAME_NARROW)
    else $error("frame length wrong");

  COV_WIDE: cover property (@(posedge sd_clk) $rose(dat_oe == 4'hF));
  COV_REFUSED: cover property (@(posedge ref_clk) status_refused);
  COV_PROG: cover property (@(posedge ref_clk) csd_prog_done);
endmodule

bind ccrr_top ccrr_top_checker u_checker (.ref_clk(ref_clk), .resetn(resetn), .sd_clk(sd_clk),
  .transfer_state(transfer_state), .status_req(status_req), .bus_wide(bus_wide),
  .secured_mode(secured_mode), .csd_prog_req(csd_prog_req), .csd_prog_data(csd_prog_data),
  .csd_value(csd_value), .scr_value(scr_value), .status_busy(status_busy), .status_done(status_done),
  .status_refused(status_refused), .csd_prog_done(csd_prog_done), .csd_prog_refused(csd_prog_refused),
  .dat_out(dat_out), .dat_oe(dat_oe));
`default_nettype wire

// [bench/ccrr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccrr_host_model (
  output logic             sd_clk,
  input  wire logic [3:0]  dat_out,
  input  wire logic [3:0]  dat_oe,
  input  wire logic        wide,
  output logic [511:0]     rx_blk,
  output logic             crc_ok,
  output int               frames
);
  logic [3:0]  ln;
  logic [15:0] crc [4];
  int          n;
  int          lanes;

  // lines are pulled up, so an undriven lane reads 1
  assign ln = (dat_out & dat_oe) | ~dat_oe;

  initial begin
    sd_clk = 1'b0;
    #7;
    forever #15 sd_clk = ~sd_clk;
  end

  initial begin
    frames = 0;
    rx_blk = '0;
    crc_ok = 1'b0;
    forever begin
      @(posedge sd_clk);
      if (ln[0] === 1'b0) begin
        lanes = wide ? 4 : 1;
        n = wide ? 128 : 512;
        crc_ok = !(wide && ln !== 4'h0);
        for (int l = 0; l < 4; l++) crc[l] = 16'h0000;
        for (int i = 0; i < n; i++) begin
          @(posedge sd_clk);
          rx_blk = wide ? {rx_blk[507:0], ln} : {rx_blk[510:0], ln[0]};
          for (int l = 0; l < lanes; l++)
            crc[l] = {crc[l][14:0], 1'b0} ^ ((ln[l] ^ crc[l][15]) ? 16'h1021 : 16'h0000);
        end
        for (int k = 15; k >= 0; k--) begin
          @(posedge sd_clk);
          for (int l = 0; l < lanes; l++)
            if (ln[l] !== crc[l][k]) crc_ok = 1'b0;
        end
        @(posedge sd_clk);
        if (ln !== 4'hF) crc_ok = 1'b0;
        frames++;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/tb_card_config_register_readback.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_card_config_register_readback;
  import ccrr_pkg::*;
  localparam logic [21:0]     SIZE = 22'h00ABCD;
  localparam logic [7:0]      RATE = 8'h32;
  localparam logic [7:0]      SPD  = 8'h04;
  // lock bits per program step, applied from index 6 down, oldest first in the list
  localparam logic [6:0][2:0] LK   = {3'h1, 3'h0, 3'h4, 3'h0, 3'h6, 3'h4, 3'h6};
  localparam logic [6:0][2:0] EK   = {3'h1, 3'h0, 3'h4, 3'h4, 3'h6, 3'h6, 3'h6};
  localparam logic [6:0]      OKV  = 7'b1110100;
  logic         ref_clk, resetn, sd_clk, transfer_state, status_req, bus_wide, secured_mode;
  logic         csd_prog_req, status_busy, status_done, status_refused, csd_prog_done;
  logic         csd_prog_refused, crc_ok;
  logic [127:0] csd_prog_data, csd_value;
  logic [63:0]  scr_value;
  logic [3:0]   dat_out, dat_oe;
  logic [511:0] rx_blk;
  int           frames, fails, n_checks;

  ccrr_top #(.DEVICE_SIZE(SIZE), .TRANSFER_RATE(RATE), .SPEED_CLASS(SPD)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .sd_clk(sd_clk), .transfer_state(transfer_state),
    .status_req(status_req), .bus_wide(bus_wide), .secured_mode(secured_mode),
    .csd_prog_req(csd_prog_req), .csd_prog_data(csd_prog_data), .csd_value(csd_value),
    .scr_value(scr_value), .status_busy(status_busy), .status_done(status_done),
    .status_refused(status_refused), .csd_prog_done(csd_prog_done),
    .csd_prog_refused(csd_prog_refused), .dat_out(dat_out), .dat_oe(dat_oe));

  ccrr_host_model host (.sd_clk(sd_clk), .dat_out(dat_out), .dat_oe(dat_oe), .wide(bus_wide),
    .rx_blk(rx_blk), .crc_ok(crc_ok), .frames(frames));

  function automatic logic [127:0] mk_csd(input logic [2:0] locks);
    logic [127:0] v;
    logic [6:0]   c;
    logic         fb;
    v = {2'h1, 6'h00, 8'h0E, 8'h00, RATE, 12'h5B5, 4'h9, 4'h0, 6'h00, SIZE, 2'b01, 7'h7F, 7'h00,
         3'h0, 3'h2, 4'h9, 6'h00, 1'b0, locks, 4'h0, 8'h01};
    c = 7'h00;
    for (int i = 127; i >= 8; i--) begin
      fb = v[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    v[7:1] = c;
    return v;
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic prog(input logic [127:0] d, input logic ok);
    @(posedge ref_clk);
    csd_prog_req <= 1'b1;
    csd_prog_data <= d;
    @(posedge ref_clk);
    csd_prog_req <= 1'b0;
    #1;
    `CHK("prog done", ok, csd_prog_done)
    `CHK("prog refused", !ok, csd_prog_refused)
    @(posedge ref_clk);
    #1;
  endtask

  task automatic st(input logic w, input logic sec, input logic ts, input logic ok, input logic poke);
    int           f0;
    logic [511:0] exp;
    f0 = frames;
    exp = {w ? 2'h2 : 2'h0, sec, 509'h0} | ({504'h0, SPD} << 440);
    @(posedge ref_clk);
    bus_wide <= w;
    secured_mode <= sec;
    transfer_state <= ts;
    status_req <= 1'b1;
    @(posedge ref_clk);
    status_req <= 1'b0;
    #1;
    `CHK("busy", ok, status_busy)
    `CHK("refused", !ok, status_refused)
    for (int i = 0; i < 3000 && ok && status_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      status_req <= poke && i == 5;
      #1;
      if (poke && i == 6)
        `CHK("busy refusal", 1'b1, status_refused)
    end
    if (ok) begin
      `CHK("done", 1'b1, status_done)
      `CHK("busy released", 1'b0, status_busy)
      `CHK("status block", exp, rx_blk)
      `CHK("crc16", 1'b1, crc_ok)
    end else
      repeat (60) @(posedge ref_clk);
    `CHK("frames", f0 + (ok ? 1 : 0), frames)
    $display("test status w=%0d ts=%0d done", w, ts);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    n_checks = 0;
    resetn = 1'b0;
    transfer_state = 1'b0;
    status_req = 1'b0;
    bus_wide = 1'b0;
    secured_mode = 1'b0;
    csd_prog_req = 1'b0;
    csd_prog_data = '0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("csd", mk_csd(3'h0), csd_value)
    `CHK("scr", {16'h0235, 48'h0}, scr_value)
    $display("test readback done");
    // low byte is garbage on purpose: the device must recompute its checksum
    for (int i = 6; i >= 0; i--) begin
      prog(mk_csd(LK[i]) ^ 128'hA5 ^ (i == 0 ? (128'h1 << 83) : 128'h0), OKV[i]);
      `CHK("csd after prog", mk_csd(EK[i]), csd_value)
    end
    $display("test program done");
    st(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    st(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
